// ---- core/erd_defs.svh ----
// Purpose: Constants of the register map decode block
// Assumes: Included by bare name; definitions only
// Notes: Register indices are pointer values, 8..15 need the point-high command
//
// Overview of operation
// - Frame status FIFO enabled only while enhancement control bit D2 is set.
// - FIFO enabled: read slots six and seven show FIFO status, not mirrors.
// - Alternate enhancement control is writable only while enhancement bit D0 is one.
// - With D0 set, writes to sync flag pattern go to alternate control instead.
// - Alternate control D6 makes write registers and alternate control readable.
// - Extended read at slot nine returns receive parameter control of the channel.
// - Extended read at slot eleven returns misc transmit/receive control register.
// - Extended read at slot fourteen returns the channel's alternate control register.
// - FIFO set, enhance clear: only FIFO; extended read needs D0 and D6.
// - Pointer bits D2..D0 of the command register select addresses zero to seven.
// - Point-high command with pointer bits adds eight for the next control access.
// - Each control read, and each control write other than to the command register, clears the pointer bits afterwards.
// - Channel select high picks channel A, low picks B, during the access.
`ifndef ERD_DEFS_SVH
`define ERD_DEFS_SVH

`define ERD_PTR_MSB 2
`define ERD_PTR_LSB 0
`define ERD_CMD_MSB 5
`define ERD_CMD_LSB 3
`define ERD_CMD_POINT_HIGH 3'h1
`define ERD_FIFO_EN_BIT 2
`define ERD_ENH_EN_BIT 0
`define ERD_EXT_READ_BIT 6

`define ERD_IDX_CMD 4'h0
`define ERD_IDX_STAT0 4'h0
`define ERD_IDX_STAT1 4'h1
`define ERD_IDX_SHARED_LO 4'h2
`define ERD_IDX_STAT2 4'h2
`define ERD_IDX_RX_PARAM 4'h3
`define ERD_IDX_STAT3 4'h3
`define ERD_IDX_TXRX_MODE 4'h4
`define ERD_IDX_TX_PARAM 4'h5
`define ERD_IDX_FIFO_LOW 4'h6
`define ERD_IDX_FIFO_HIGH 4'h7
`define ERD_IDX_SYNC_FLAG 4'h7
`define ERD_IDX_DATA 4'h8
`define ERD_IDX_SLOT_NINE 4'h9
`define ERD_IDX_SHARED_HI 4'h9
`define ERD_IDX_SLOT_TEN 4'hA
`define ERD_IDX_MISC_CTL 4'hA
`define ERD_IDX_SLOT_ELEVEN 4'hB
`define ERD_IDX_SLOT_THIRTEEN 4'hD
`define ERD_IDX_SLOT_FOURTEEN 4'hE
`define ERD_IDX_ENH_CTL 4'hF
`define ERD_IDX_SLOT_FIFTEEN 4'hF

`define ERD_RESET_BYTE 8'h00

`endif

// ---- core/erd_pkg.sv ----
// Purpose: Types shared by the register map decode files
// Assumes: Nothing
// Notes: Constants live in erd_defs.svh
package erd_pkg;
   typedef enum logic [1:0] {SRC_STATUS, SRC_WREG, SRC_ALT} erd_src_e;
   typedef enum logic {ST_IDLE, ST_READ} erd_state_e;
   typedef logic [7:0] erd_byte_t;
endpackage

// ---- core/erd_wreg_mem.sv ----
// Purpose: Storage of the write registers, 16 per channel
// Assumes: Address is {channel A, index}
// Notes: Read data is registered, one cycle latency
`timescale 1ns/1ns
`include "erd_defs.svh"
module erd_wreg_mem
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic we_in,
   input wire logic [4:0] waddr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [4:0] raddr_in,
   output logic [7:0] rdata_out
);
   typedef struct packed
   {
      logic [31:0][7:0] mem;
      logic [7:0] rdata;
   } erd_mem_s;

   erd_mem_s q;
   erd_mem_s next_q;

   always_comb
   begin
      next_q = q;
      next_q.rdata = q.mem[raddr_in];
      if (we_in)
      begin
         next_q.mem[waddr_in] = wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign rdata_out = q.rdata;
endmodule // erd_wreg_mem

// ---- core/erd_map_decode.sv ----
// Purpose: Maps an access index onto read source and write target
// Assumes: Index is the already formed 4-bit register address
// Notes: Purely combinational; the top registers all results
`timescale 1ns/1ns
`include "erd_defs.svh"
module erd_map_decode
(
   input wire logic [3:0] idx_in,
   input wire logic chan_a_in,
   input wire logic fifo_en_in,
   input wire logic enh_en_in,
   input wire logic ext_bit_in,
   output erd_pkg::erd_src_e rd_src_out,
   output logic [3:0] rd_idx_out,
   output logic wr_to_alt_out,
   output logic wr_chan_a_out
);
   logic ext_rd;

   // Extended read needs both bits, so the FIFO bit alone never enables it
   function automatic logic ext_read(input logic enh, input logic ext_bit);
      ext_read = enh & ext_bit;
   endfunction

   always_comb
   begin
      ext_rd = ext_read(enh_en_in, ext_bit_in);
      rd_src_out = erd_pkg::SRC_STATUS;
      rd_idx_out = idx_in;
      case (idx_in)
         `ERD_IDX_TXRX_MODE, `ERD_IDX_TX_PARAM:
         begin
            if (ext_rd)
            begin
               rd_src_out = erd_pkg::SRC_WREG;
            end
            else
            begin
               rd_idx_out = (idx_in == `ERD_IDX_TXRX_MODE) ? `ERD_IDX_STAT0 : `ERD_IDX_STAT1;
            end
         end
         `ERD_IDX_FIFO_LOW, `ERD_IDX_FIFO_HIGH:
         begin
            if (!fifo_en_in)
            begin
               rd_idx_out = (idx_in == `ERD_IDX_FIFO_LOW) ? `ERD_IDX_STAT2 : `ERD_IDX_STAT3;
            end
         end
         `ERD_IDX_SLOT_NINE:
         begin
            if (ext_rd)
            begin
               rd_src_out = erd_pkg::SRC_WREG;
               rd_idx_out = `ERD_IDX_RX_PARAM;
            end
            else
            begin
               rd_idx_out = `ERD_IDX_SLOT_THIRTEEN;
            end
         end
         `ERD_IDX_SLOT_ELEVEN:
         begin
            if (ext_rd)
            begin
               rd_src_out = erd_pkg::SRC_WREG;
               rd_idx_out = `ERD_IDX_MISC_CTL;
            end
            else
            begin
               rd_idx_out = `ERD_IDX_SLOT_FIFTEEN;
            end
         end
         `ERD_IDX_SLOT_FOURTEEN:
         begin
            if (ext_rd)
            begin
               rd_src_out = erd_pkg::SRC_ALT;
            end
            else
            begin
               rd_idx_out = `ERD_IDX_SLOT_TEN;
            end
         end
         default:
         begin
            rd_idx_out = idx_in;
         end
      endcase
      wr_to_alt_out = enh_en_in && (idx_in == `ERD_IDX_SYNC_FLAG);
      // Shared write registers live in the channel B slot
      wr_chan_a_out = chan_a_in;
      if (idx_in == `ERD_IDX_SHARED_LO || idx_in == `ERD_IDX_SHARED_HI)
      begin
         wr_chan_a_out = 1'b0;
      end
   end
endmodule // erd_map_decode

// ---- core/erd_reg_map.sv ----
// Purpose: Host register port: pointer, channel select, enhancement decode
// Assumes: Host strobes are one-cycle pulses synchronous to clk_sys_in
// Notes: Reads answer two cycles after the strobe; writes take one cycle
`timescale 1ns/1ns
`include "erd_defs.svh"
module erd_reg_map
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic chip_sel_in,
   input wire logic rd_req_in,
   input wire logic wr_req_in,
   input wire logic data_sel_in,
   input wire logic chan_a_sel_in,
   input wire logic [7:0] wdata_in,
   input wire logic [127:0] status_a_in,
   input wire logic [127:0] status_b_in,
   output logic [7:0] rdata_out,
   output logic rdata_valid_out,
   output logic wr_pulse_out,
   output logic [3:0] wr_index_out,
   output logic wr_chan_a_out,
   output logic [7:0] wr_data_out,
   output logic [1:0] fifo_enable_out,
   output logic [1:0] enhance_enable_out,
   output logic [7:0] alt_ctrl_a_out,
   output logic [7:0] alt_ctrl_b_out,
   output logic [3:0] pointer_out
);
   typedef struct packed
   {
      erd_pkg::erd_state_e st;
      logic [2:0] ptr;
      logic ptr_high;
      logic chan_a;
      erd_pkg::erd_src_e src;
      logic [3:0] rd_idx;
      erd_pkg::erd_byte_t alt_a;
      erd_pkg::erd_byte_t alt_b;
      erd_pkg::erd_byte_t enh_a;
      erd_pkg::erd_byte_t enh_b;
      erd_pkg::erd_byte_t rdata;
      logic rvalid;
      logic wpulse;
      logic [3:0] widx;
      logic wchan_a;
      erd_pkg::erd_byte_t wdata;
   } erd_top_s;

   erd_top_s q;
   erd_top_s next_q;

   logic [3:0] acc_idx;
   erd_pkg::erd_byte_t sel_enh;
   erd_pkg::erd_byte_t sel_alt;
   logic wr_acc;
   logic rd_acc;
   erd_pkg::erd_src_e dec_src;
   logic [3:0] dec_idx;
   logic dec_to_alt;
   logic dec_wchan_a;
   logic mem_we;
   erd_pkg::erd_byte_t mem_rdata;

   function automatic erd_pkg::erd_byte_t pick_byte(input logic [127:0] bank, input logic [3:0] idx);
      pick_byte = bank[{idx, 3'h0} +: 8];
   endfunction

   // Strobes during a pending read are dropped; both strobes at once is not an access
   assign wr_acc = chip_sel_in && wr_req_in && !rd_req_in && (q.st == erd_pkg::ST_IDLE);
   assign rd_acc = chip_sel_in && rd_req_in && !wr_req_in && (q.st == erd_pkg::ST_IDLE);
   assign acc_idx = data_sel_in ? `ERD_IDX_DATA : {q.ptr_high, q.ptr};
   assign sel_enh = chan_a_sel_in ? q.enh_a : q.enh_b;
   assign sel_alt = chan_a_sel_in ? q.alt_a : q.alt_b;
   assign mem_we = wr_acc && !dec_to_alt;

   erd_map_decode u_decode
   (
      .idx_in(acc_idx),
      .chan_a_in(chan_a_sel_in),
      .fifo_en_in(sel_enh[`ERD_FIFO_EN_BIT]),
      .enh_en_in(sel_enh[`ERD_ENH_EN_BIT]),
      .ext_bit_in(sel_alt[`ERD_EXT_READ_BIT]),
      .rd_src_out(dec_src),
      .rd_idx_out(dec_idx),
      .wr_to_alt_out(dec_to_alt),
      .wr_chan_a_out(dec_wchan_a)
   );

   erd_wreg_mem u_wreg_mem
   (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .we_in(mem_we),
      .waddr_in({dec_wchan_a, acc_idx}),
      .wdata_in(wdata_in),
      .raddr_in({chan_a_sel_in, dec_idx}),
      .rdata_out(mem_rdata)
   );

   always_comb
   begin
      next_q = q;
      next_q.wpulse = 1'b0;
      next_q.rvalid = 1'b0;
      case (q.st)
         erd_pkg::ST_IDLE:
         begin
            if (wr_acc)
            begin
               if (dec_to_alt)
               begin
                  if (chan_a_sel_in)
                  begin
                     next_q.alt_a = wdata_in;
                  end
                  else
                  begin
                     next_q.alt_b = wdata_in;
                  end
               end
               else
               begin
                  next_q.wpulse = 1'b1;
                  next_q.widx = acc_idx;
                  next_q.wchan_a = dec_wchan_a;
                  next_q.wdata = wdata_in;
                  if (acc_idx == `ERD_IDX_ENH_CTL)
                  begin
                     if (chan_a_sel_in)
                     begin
                        next_q.enh_a = wdata_in;
                     end
                     else
                     begin
                        next_q.enh_b = wdata_in;
                     end
                  end
               end
               if (!data_sel_in)
               begin
                  // Only the command register loads the pointer; all others clear it
                  if (acc_idx == `ERD_IDX_CMD)
                  begin
                     next_q.ptr = wdata_in[`ERD_PTR_MSB:`ERD_PTR_LSB];
                     next_q.ptr_high = (wdata_in[`ERD_CMD_MSB:`ERD_CMD_LSB] == `ERD_CMD_POINT_HIGH);
                  end
                  else
                  begin
                     next_q.ptr = 3'h0;
                     next_q.ptr_high = 1'b0;
                  end
               end
            end
            else if (rd_acc)
            begin
               next_q.st = erd_pkg::ST_READ;
               next_q.src = dec_src;
               next_q.rd_idx = dec_idx;
               next_q.chan_a = chan_a_sel_in;
               if (!data_sel_in)
               begin
                  next_q.ptr = 3'h0;
                  next_q.ptr_high = 1'b0;
               end
            end
         end
         erd_pkg::ST_READ:
         begin
            case (q.src)
               erd_pkg::SRC_WREG:
               begin
                  next_q.rdata = mem_rdata;
               end
               erd_pkg::SRC_ALT:
               begin
                  next_q.rdata = q.chan_a ? q.alt_a : q.alt_b;
               end
               default:
               begin
                  // FIFO status bytes arrive in slots six and seven of the status bank
                  next_q.rdata = pick_byte(q.chan_a ? status_a_in : status_b_in, q.rd_idx);
               end
            endcase
            next_q.rvalid = 1'b1;
            next_q.st = erd_pkg::ST_IDLE;
         end
         default:
         begin
            next_q.st = erd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign rdata_out = q.rdata;
   assign rdata_valid_out = q.rvalid;
   assign wr_pulse_out = q.wpulse;
   assign wr_index_out = q.widx;
   assign wr_chan_a_out = q.wchan_a;
   assign wr_data_out = q.wdata;
   assign fifo_enable_out = {q.enh_a[`ERD_FIFO_EN_BIT], q.enh_b[`ERD_FIFO_EN_BIT]};
   assign enhance_enable_out = {q.enh_a[`ERD_ENH_EN_BIT], q.enh_b[`ERD_ENH_EN_BIT]};
   assign alt_ctrl_a_out = q.alt_a;
   assign alt_ctrl_b_out = q.alt_b;
   assign pointer_out = {q.ptr_high, q.ptr};
endmodule // erd_reg_map

// ---- sim/erd_monitor.sv ----
// Purpose: Checker of the register port decode
// Assumes: Bound to erd_reg_map; one clock domain
// Notes: Keeps its own copy of the read busy cycle
`timescale 1ns/1ns
module erd_monitor
(
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic chip_sel_in,
   input wire logic rd_req_in,
   input wire logic wr_req_in,
   input wire logic data_sel_in,
   input wire logic chan_a_sel_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_pulse_out,
   input wire logic [3:0] wr_index_out,
   input wire logic wr_chan_a_out,
   input wire logic [1:0] fifo_enable_out,
   input wire logic [1:0] enhance_enable_out,
   input wire logic [7:0] alt_ctrl_a_out,
   input wire logic [7:0] alt_ctrl_b_out,
   input wire logic [3:0] pointer_out
);
   logic busy;
   logic ca_q;
   logic [7:0] wd_q;
   wire rt = chip_sel_in & rd_req_in & ~wr_req_in & ~busy;
   wire wt = chip_sel_in & wr_req_in & ~rd_req_in & ~busy;
   wire cw = wt & ~data_sel_in;
   wire enh = chan_a_sel_in ? enhance_enable_out[1] : enhance_enable_out[0];
   wire p7 = cw & enh & pointer_out == 4'h7;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   always_ff @(posedge clk_sys_in)
   begin
      busy <= ~reset_in & rt;
      ca_q <= chan_a_sel_in;
      wd_q <= wdata_in;
   end
   AST_PTR_LOAD: assert property (cw & pointer_out == 4'h0 |=>
      pointer_out == {wd_q[5:3] == 3'h1, wd_q[2:0]}) else $error("pointer load wrong");
   AST_PTR_CLR: assert property ((rt & ~data_sel_in) | (cw & pointer_out != 4'h0) |=>
      pointer_out == 4'h0) else $error("pointer not cleared");
   AST_PTR_KEEP: assert property ((rt | wt) & data_sel_in |=> $stable(pointer_out))
      else $error("data access moved pointer");
   AST_WR_PULSE: assert property (cw & pointer_out != 4'h0 & ~p7 |=>
      wr_pulse_out && wr_index_out == $past(pointer_out)) else $error("write index wrong");
   AST_ALT_ROUTE: assert property (p7 & chan_a_sel_in |=>
      !wr_pulse_out && alt_ctrl_a_out == wd_q) else $error("alternate write lost");
   AST_ALT_HOLD: assert property (!(p7 & ~chan_a_sel_in) |=> $stable(alt_ctrl_b_out))
      else $error("alternate changed");
   AST_FIFO_EN: assert property (cw & chan_a_sel_in & pointer_out == 4'hF |=>
      fifo_enable_out[1] == wd_q[2] && enhance_enable_out[1] == wd_q[0]) else $error("enable bits wrong");
   AST_EN_HOLD: assert property (!(cw & pointer_out == 4'hF) |=> $stable(fifo_enable_out))
      else $error("fifo enable changed");
   AST_SHARED: assert property (cw & (pointer_out == 4'h2 || pointer_out == 4'h9) |=>
      !wr_chan_a_out) else $error("shared write not shared");
   AST_WR_CHAN: assert property (cw & pointer_out inside {4'h3, 4'h4, 4'hA} |=>
      wr_chan_a_out == ca_q) else $error("write channel wrong");
endmodule // erd_monitor
bind erd_reg_map erd_monitor u_mon (.*);

// ---- sim/erd_host_model.sv ----
// Purpose: Host processor on the register port
// Assumes: Strobes are one-cycle pulses set at the falling edge
// Notes: Released lines show inverted values so stale data is not read
`timescale 1ns/1ns
module erd_host_model
(
   input wire logic clk_sys_in,
   input wire logic [7:0] rdata_in,
   input wire logic rdata_valid_in,
   output logic cs_out,
   output logic rd_out,
   output logic wr_out,
   output logic dsel_out,
   output logic cha_out,
   output logic [7:0] wdata_out
);
   initial
   begin
      cs_out = 1'b0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      dsel_out = 1'b0;
      cha_out = 1'b0;
      wdata_out = 8'h00;
   end
   task automatic put(input logic r, input logic a, input logic d, input logic [7:0] v);
      @(negedge clk_sys_in);
      cs_out = 1'b1;
      rd_out = r;
      wr_out = ~r;
      cha_out = a;
      dsel_out = d;
      wdata_out = v;
      @(negedge clk_sys_in);
      cs_out = 1'b0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      cha_out = ~a;
      dsel_out = ~d;
      wdata_out = ~v;
   endtask
   task automatic wr(input logic a, input logic d, input logic [7:0] v);
      put(1'b0, a, d, v);
   endtask
   // Returns in the cycle the answer stands; next strobe is one cycle later
   task automatic rd(input logic a, input logic d, output logic [7:0] v, output logic ok);
      put(1'b1, a, d, ~wdata_out);
      @(negedge clk_sys_in);
      v = rdata_in;
      ok = rdata_valid_in;
   endtask
   task automatic sel(input logic a, input logic [3:0] k);
      wr(a, 1'b0, {2'b00, k[3] ? 3'h1 : 3'h0, k[2:0]});
   endtask
endmodule // erd_host_model

// ---- sim/erd_reg_map_tb.sv ----
// Purpose: Self-checking bench of the register map decode
// Assumes: Host model drives the port; reference model below
// Notes: Random indices with biased enhancement writes
`timescale 1ns/1ns
module erd_reg_map_tb;
   logic clk_sys_in = 1'b0;
   logic reset_in, chip_sel_in, rd_req_in, wr_req_in, data_sel_in, chan_a_sel_in;
   logic rdata_valid_out, wr_pulse_out, wr_chan_a_out;
   logic [7:0] wdata_in, rdata_out, wr_data_out, alt_ctrl_a_out, alt_ctrl_b_out;
   logic [127:0] status_a_in, status_b_in;
   logic [3:0] wr_index_out, pointer_out, i;
   logic [1:0] fifo_enable_out, enhance_enable_out;
   logic [31:0] rs = 32'h00010D2F;
   logic [31:0] r;
   logic [7:0] v, d;
   logic a, ok, sh;
   logic [7:0] wr_m [2][16] = '{default: 8'h00};
   logic [7:0] alt_m [2] = '{default: 8'h00};
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   always #4 clk_sys_in = ~clk_sys_in;
   erd_reg_map u_dut (.*);
   erd_host_model u_host (.clk_sys_in, .rdata_in(rdata_out), .rdata_valid_in(rdata_valid_out),
      .cs_out(chip_sel_in), .rd_out(rd_req_in), .wr_out(wr_req_in), .dsel_out(data_sel_in),
      .cha_out(chan_a_sel_in), .wdata_out(wdata_in));
   function automatic logic [31:0] rnd();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction
   function automatic logic [7:0] st(input logic c, input logic [3:0] k);
      return c ? status_a_in[k * 8 +: 8] : status_b_in[k * 8 +: 8];
   endfunction
   function automatic logic [7:0] exp_rd(input logic c, input logic [3:0] k);
      logic x;
      x = wr_m[c][15][0] & alt_m[c][6];
      if (x && (k == 4'h4 || k == 4'h5)) return wr_m[c][k];
      if (x && k == 4'h9) return wr_m[c][3];
      if (x && k == 4'hB) return wr_m[c][10];
      if (x && k == 4'hE) return alt_m[c];
      if (k == 4'h9) return st(c, 4'hD);
      if (k == 4'hB) return st(c, 4'hF);
      if (k == 4'hE) return st(c, 4'hA);
      if (k == 4'h4 || k == 4'h5 || (k > 4'h5 && k < 4'h8 && !wr_m[c][15][2])) return st(c, k & 4'h3);
      return st(c, k);
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         n_mismatch++;
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial
   begin
      reset_in = 1'b1;
      status_a_in = '0;
      status_b_in = '0;
      repeat (16) @(negedge clk_sys_in);
      reset_in = 1'b0;
      chk("pointer", {4'h0, pointer_out}, 8'h00);
      chk("alt", alt_ctrl_a_out | alt_ctrl_b_out, 8'h00);
      chk("enables", {4'h0, fifo_enable_out, enhance_enable_out}, 8'h00);
      $display("test reset done");
      for (int n = 0; n < 400; n++)
      begin
         r = rnd();
         status_a_in = {rnd(), rnd(), rnd(), rnd()};
         status_b_in = {rnd(), rnd(), rnd(), rnd()};
         a = r[0];
         i = r[7:5] == 3'h0 ? 4'hF : r[7:5] == 3'h1 ? 4'h7 : r[4:1];
         v = i == 4'h0 ? r[15:8] & 8'hC0 : r[15:8];
         u_host.sel(r[16], i);
         chk("pointer", {4'h0, pointer_out}, {4'h0, i});
         if (r[17])
         begin
            u_host.rd(a, 1'b1, d, ok);
            chk("data read", d, st(a, 4'h8));
            chk("pointer kept", {4'h0, pointer_out}, {4'h0, i});
         end
         if (r[18])
         begin
            u_host.rd(a, 1'b0, d, ok);
            chk("valid", {7'h0, ok}, 8'h01);
            chk("read", d, exp_rd(a, i));
         end
         else
         begin
            u_host.wr(a, 1'b0, v);
            sh = i == 4'h2 || i == 4'h9;
            if (i == 4'h7 && wr_m[a][15][0])
            begin
               alt_m[a] = v;
               chk("pulse", {7'h0, wr_pulse_out}, 8'h00);
            end
            else if (i != 4'h0)
            begin
               wr_m[a & ~sh][i] = v;
               chk("pulse", {7'h0, wr_pulse_out}, 8'h01);
               chk("index", {4'h0, wr_index_out}, {4'h0, i});
               chk("wdata", wr_data_out, v);
               chk("wchan", {7'h0, wr_chan_a_out}, {7'h0, a & ~sh});
            end
            chk("alt a", alt_ctrl_a_out, alt_m[1]);
            chk("alt b", alt_ctrl_b_out, alt_m[0]);
            chk("enables", {4'h0, fifo_enable_out, enhance_enable_out},
               {4'h0, wr_m[1][15][2], wr_m[0][15][2], wr_m[1][15][0], wr_m[0][15][0]});
         end
         chk("pointer", {4'h0, pointer_out}, 8'h00);
      end
      $display("test random done");
      // Corner cases: alternate register round trip, then the FIFO bit alone must not open extended read
      u_host.sel(1'b0, 4'hF);
      u_host.wr(1'b0, 1'b0, 8'h05);
      wr_m[0][15] = 8'h05;
      u_host.sel(1'b0, 4'h7);
      u_host.wr(1'b0, 1'b0, 8'h40);
      alt_m[0] = 8'h40;
      chk("pulse", {7'h0, wr_pulse_out}, 8'h00);
      chk("alt b", alt_ctrl_b_out, 8'h40);
      u_host.sel(1'b0, 4'hE);
      u_host.rd(1'b0, 1'b0, d, ok);
      chk("read", d, 8'h40);
      u_host.sel(1'b0, 4'hF);
      u_host.wr(1'b0, 1'b0, 8'h04);
      wr_m[0][15] = 8'h04;
      u_host.sel(1'b0, 4'hE);
      u_host.rd(1'b0, 1'b0, d, ok);
      chk("read", d, st(1'b0, 4'hA));
      // Data write between pointer load and control access must leave the pointer alone
      u_host.sel(1'b1, 4'h3);
      u_host.wr(1'b1, 1'b1, 8'hA5);
      chk("index", {4'h0, wr_index_out}, 8'h08);
      chk("pointer kept", {4'h0, pointer_out}, 8'h03);
      u_host.wr(1'b1, 1'b0, 8'h5A);
      wr_m[1][3] = 8'h5A;
      chk("index", {4'h0, wr_index_out}, 8'h03);
      chk("pointer", {4'h0, pointer_out}, 8'h00);
      $display("test corner done");
      give_verdict();
   end
endmodule // erd_reg_map_tb
